// file: rtl/dma_defines.svh
// Constants for the four-channel DMA control, status and arbitration block.
// Assumes it is included by bare name from the package only.
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

// ==========================================================================
// Command/status register layout
`define DMA_NUM_CH            4
`define DMA_EN_LSB            0
`define DMA_TC_LSB            4
`define DMA_ACT_LSB           8
`define DMA_DONE_LSB          12
`define DMA_WAIT_LSB          16
`define DMA_PRIO_BIT          20
`define DMA_THROTTLE_BIT      21
`define DMA_RSVD_LSB          22
`define DMA_RSVD_WIDTH        10

// ==========================================================================
// State RAM layout: eight words per channel
`define DMA_RAM_WORDS_PER_CH  8
`define DMA_RAM_WORDS         32
`define DMA_RAM_WORD_SRC      3'h0
`define DMA_RAM_WORD_DST      3'h1
`define DMA_RAM_WORD_CNT      3'h2

// ==========================================================================
// Throttle: DMA clocks allowed per user clock
`define DMA_RUN_LIMIT_FULL    3'h4
`define DMA_RUN_LIMIT_THR     3'h1

// Address step per serviced request and last-unit count
`define DMA_ADDR_STEP         32'h4
`define DMA_CNT_LAST          32'h1

`endif

// file: rtl/dma_pkg.sv
// Types shared by the DMA control block and its state RAM.
// Assumes the constants header is on the include path.
package dma_pkg;
  `include "dma_defines.svh"

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAVE,
    ST_SERVE,
    ST_DESC
  } dma_state_t;

  typedef logic [1:0] chan_t;
  typedef logic [3:0] chan_mask_t;
endpackage

// file: rtl/state_ram_if.sv
// Carrier between the DMA sequencer and its channel state RAM.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface state_ram_if;
  logic        we;
  logic [4:0]  waddr;
  logic [31:0] wdata;
  logic [4:0]  raddr;
  logic [31:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: rtl/dma_state_ram.sv
// Channel state RAM: 32 words, one write port, one read port with registered data.
// Assumes write inputs arrive from flops on the same clock.
`timescale 1ns/1ns
module dma_state_ram
  import dma_pkg::*;
#(
  parameter int unsigned WORDS = `DMA_RAM_WORDS
) (
  input  wire logic   clock_i,
  state_ram_if.mem    ram
);

  // ========================================================================
  // Storage
  logic [31:0] mem_q [WORDS];
  logic [31:0] rdata_ff;

  generate
    if (WORDS != `DMA_RAM_WORDS) begin : g_bad_words
      $error("dma_state_ram: WORDS must be 32");
    end
  endgenerate

  // Write port and registered read
  always_ff @(posedge clock_i) begin
    if (ram.we) begin
      mem_q[ram.waddr] <= ram.wdata;
    end
    rdata_ff <= mem_q[ram.raddr];
  end

  assign ram.rdata = rdata_ff;

endmodule

// file: rtl/dma_channel_control_priority.sv
// Four-channel DMA control: command/status register, arbitration, sequencing,
// state saving. Assumes a same-clock bus unit and setup/flush strobes from the core.
// Functional notes
// - Enable bits 3-0 run channels; clearing suspends after current request completes.
// - Re-enabling a suspended channel resumes from its current addresses and count.
// - Hardware never clears enable; software clears it before setup.
// - Suspend-on-interrupt option holds all channels during interrupt context switch.
// - Setup on an active channel aborts its transfer immediately and reloads.
// - Channel aborted by setup gets no done flag; old done and terminal count kept.
// - Fixed mode serves channel 0 first, channel 3 last.
// - Rotating mode: serviced channel lowest, next channel number highest.
// - Priority mode bit 20: zero fixed, one rotating.
// - Terminal count set on count zero or null pointer, after bus activity.
// - Writing terminal count flags never affects transfers.
// - Demand mode active per request; block mode active across requests until block end or the run limit forces idle.
// - Active flags are read-only; writes ignored.
// - Done set on count zero, null pointer or end-of-process input.
// - Done cleared only by software; setup and enable leave it.
// - Wait bit set on descriptor read; wait function blocks next read until cleared.
// - Throttle set: one DMA clock per user clock; clear: four.
// - Only bits 21-0 implemented; upper bits read zero.
// - Eight RAM words per channel; preemption saves source, destination, count.
// - Flush copies a set-up channel's live state into its RAM area.
// - Normal termination clears active only after bus activity finished.
// - Normal termination pulses the channel's interrupt-pending set line.
`timescale 1ns/1ns
module dma_channel_control_priority
  import dma_pkg::*;
#(
  parameter int unsigned CHANNELS = `DMA_NUM_CH
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [31:0] sfr_wdata_i,
  output logic      [31:0] sfr_rdata_o,
  input  wire logic        setup_valid_i,
  input  wire logic [1:0]  setup_chan_i,
  input  wire logic        setup_chained_i,
  input  wire logic        setup_block_i,
  input  wire logic        setup_wait_en_i,
  input  wire logic [31:0] setup_count_i,
  input  wire logic [31:0] setup_src_i,
  input  wire logic [31:0] setup_dst_i,
  input  wire logic        interrupt_control_register_suspend_i,
  input  wire logic        ctx_switch_i,
  input  wire logic        flush_i,
  input  wire logic [1:0]  flush_chan_i,
  input  wire logic [3:0]  dreq_i,
  input  wire logic [3:0]  end_of_process_inputs_n_i,
  output logic             bus_req_o,
  output logic      [1:0]  bus_chan_o,
  output logic      [31:0] bus_src_o,
  output logic      [31:0] bus_dst_o,
  input  wire logic        bus_done_i,
  output logic             desc_req_o,
  output logic      [1:0]  desc_chan_o,
  input  wire logic        desc_done_i,
  input  wire logic        desc_null_i,
  input  wire logic [31:0] desc_count_i,
  input  wire logic [31:0] desc_src_i,
  input  wire logic [31:0] desc_dst_i,
  output logic      [3:0]  interrupt_pending_set_o,
  input  wire logic [4:0]  ram_rd_addr_i,
  output logic      [31:0] ram_rdata_o
);

  generate
    if (CHANNELS != `DMA_NUM_CH) begin : g_bad_channels
      $error("dma_channel_control_priority: CHANNELS must be 4");
    end
  endgenerate

  // ========================================================================
  // Pin synchronisers
  logic [3:0] dreq_meta_ff, dreq_sync_ff, eop_meta_ff, eop_sync_ff, eop_prev_ff;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dreq_meta_ff <= 4'h0;
      dreq_sync_ff <= 4'h0;
      eop_meta_ff  <= 4'hf;
      eop_sync_ff  <= 4'hf;
      eop_prev_ff  <= 4'hf;
    end else begin
      dreq_meta_ff <= dreq_i;
      dreq_sync_ff <= dreq_meta_ff;
      eop_meta_ff  <= end_of_process_inputs_n_i;
      eop_sync_ff  <= eop_meta_ff;
      eop_prev_ff  <= eop_sync_ff;
    end
  end

  // ========================================================================
  // State declarations
  dma_state_t        state_ff, nxt_state;
  chan_mask_t        enable_ff, nxt_enable, tc_ff, nxt_tc, active_ff, nxt_active;
  chan_mask_t        done_ff, nxt_done, wait_ff, nxt_wait, irq_ff, nxt_irq;
  logic              prio_ff, nxt_prio, throttle_ff, nxt_throttle;
  chan_mask_t        setup_ok_ff, nxt_setup_ok, chained_ff, nxt_chained;
  chan_mask_t        block_ff, nxt_block, wait_en_ff, nxt_wait_en;
  chan_mask_t        desc_need_ff, nxt_desc_need, eop_pend_ff, nxt_eop_pend;
  logic [3:0][31:0]  cnt_ff, nxt_cnt, src_ff, nxt_src, dst_ff, nxt_dst;
  logic [31:0]       xsrc_ff, nxt_xsrc, xdst_ff, nxt_xdst;
  chan_t             cur_ff, nxt_cur, last_ff, nxt_last, save_ch_ff, nxt_save_ch;
  logic              have_last_ff, nxt_have_last, ret_serve_ff, nxt_ret_serve;
  logic              flush_pend_ff, nxt_flush_pend;
  chan_t             flush_ch_ff, nxt_flush_ch;
  logic [2:0]        widx_ff, nxt_widx, run_cnt_ff, nxt_run_cnt;
  logic              ram_we_ff, nxt_ram_we;
  logic [4:0]        ram_waddr_ff, nxt_ram_waddr;
  logic [31:0]       ram_wdata_ff, nxt_ram_wdata;

  chan_mask_t        eff_en, elig, desc_ready, eop_fall;
  chan_t             grant_ch, desc_ch;
  logic              run_ok, cnt_last;
  logic [2:0]        run_limit;

  // Lowest offset from start with a request wins
  function automatic chan_t pick_first(input chan_mask_t req, input chan_t start);
    chan_t idx;
    pick_first = start;
    for (int i = 3; i >= 0; i--) begin
      idx = start + chan_t'(i);
      if (req[idx]) begin
        pick_first = idx;
      end
    end
  endfunction

  // ========================================================================
  // Arbitration terms
  // Context switch suspends
  assign eff_en     = (interrupt_control_register_suspend_i && ctx_switch_i) ? 4'h0 : enable_ff;
  assign elig       = setup_ok_ff & eff_en & dreq_sync_ff & ~desc_need_ff;
  assign desc_ready = setup_ok_ff & eff_en & desc_need_ff & ~(wait_en_ff & wait_ff);
  assign eop_fall   = eop_prev_ff & ~eop_sync_ff;
  assign grant_ch   = pick_first(elig, prio_ff ? last_ff + 2'h1 : 2'h0);
  assign desc_ch    = pick_first(desc_ready, 2'h0);
  assign run_limit  = throttle_ff ? `DMA_RUN_LIMIT_THR : `DMA_RUN_LIMIT_FULL;
  assign run_ok     = run_cnt_ff < run_limit;
  assign cnt_last   = cnt_ff[cur_ff] == `DMA_CNT_LAST;

  // ========================================================================
  // Next-state computation
  always_comb begin
    nxt_state = state_ff;          nxt_enable = enable_ff;       nxt_tc = tc_ff;
    nxt_active = active_ff;        nxt_done = done_ff;           nxt_wait = wait_ff;
    nxt_irq = 4'h0;                nxt_prio = prio_ff;           nxt_throttle = throttle_ff;
    nxt_setup_ok = setup_ok_ff;    nxt_chained = chained_ff;     nxt_block = block_ff;
    nxt_wait_en = wait_en_ff;      nxt_desc_need = desc_need_ff; nxt_cnt = cnt_ff;
    nxt_src = src_ff;              nxt_dst = dst_ff;             nxt_xsrc = xsrc_ff;
    nxt_xdst = xdst_ff;            nxt_cur = cur_ff;             nxt_last = last_ff;
    nxt_save_ch = save_ch_ff;      nxt_have_last = have_last_ff; nxt_ret_serve = ret_serve_ff;
    nxt_widx = widx_ff;            nxt_ram_we = 1'b0;            nxt_ram_waddr = ram_waddr_ff;
    nxt_ram_wdata = ram_wdata_ff;
    nxt_flush_pend = flush_pend_ff | flush_i;
    nxt_flush_ch = flush_i ? flush_chan_i : flush_ch_ff;
    nxt_eop_pend = eop_pend_ff | (eop_fall & setup_ok_ff);
    // DMA clocks counted, reset by a user clock
    nxt_run_cnt = (state_ff == ST_IDLE) ? 3'h0 :
                  (run_cnt_ff == 3'h7) ? run_cnt_ff : run_cnt_ff + 3'h1;

    // Software write; hardware sets below win over it
    if (sfr_wr_i) begin
      nxt_enable = sfr_wdata_i[`DMA_EN_LSB +: 4];
      nxt_tc     = sfr_wdata_i[`DMA_TC_LSB +: 4];
      nxt_done   = sfr_wdata_i[`DMA_DONE_LSB +: 4];
      nxt_wait   = sfr_wdata_i[`DMA_WAIT_LSB +: 4];
      nxt_prio   = sfr_wdata_i[`DMA_PRIO_BIT];
      nxt_throttle = sfr_wdata_i[`DMA_THROTTLE_BIT];
    end

    case (state_ff)
      ST_IDLE: begin
        if (flush_pend_ff) begin
          nxt_flush_pend = flush_i;
          if (setup_ok_ff[flush_ch_ff]) begin
            nxt_save_ch = flush_ch_ff;
            nxt_ret_serve = 1'b0;
            nxt_widx = 3'h0;
            nxt_state = ST_SAVE;
          end
        end else if (desc_ready != 4'h0 && run_ok) begin
          nxt_cur = desc_ch;
          nxt_state = ST_DESC;
        end else if (elig != 4'h0 && run_ok) begin
          nxt_cur = grant_ch;
          if (have_last_ff && last_ff != grant_ch && setup_ok_ff[last_ff]) begin
            nxt_save_ch = last_ff;
            nxt_ret_serve = 1'b1;
            nxt_widx = 3'h0;
            nxt_state = ST_SAVE;
          end else begin
            nxt_active[grant_ch] = 1'b1;
            nxt_xsrc = src_ff[grant_ch];
            nxt_xdst = dst_ff[grant_ch];
            nxt_state = ST_SERVE;
          end
        end
      end
      ST_SAVE: begin
        nxt_ram_we = 1'b1;
        nxt_ram_waddr = {save_ch_ff, widx_ff};
        nxt_ram_wdata = (widx_ff == `DMA_RAM_WORD_SRC) ? src_ff[save_ch_ff] :
                        (widx_ff == `DMA_RAM_WORD_DST) ? dst_ff[save_ch_ff] : cnt_ff[save_ch_ff];
        nxt_widx = widx_ff + 3'h1;
        if (widx_ff == `DMA_RAM_WORD_CNT) begin
          nxt_state = ST_IDLE;
          if (ret_serve_ff && elig[cur_ff]) begin
            nxt_active[cur_ff] = 1'b1;
            nxt_xsrc = src_ff[cur_ff];
            nxt_xdst = dst_ff[cur_ff];
            nxt_state = ST_SERVE;
          end
        end
      end
      ST_SERVE: begin
        if (bus_done_i) begin
          nxt_cnt[cur_ff] = cnt_ff[cur_ff] - `DMA_CNT_LAST;
          nxt_src[cur_ff] = src_ff[cur_ff] + `DMA_ADDR_STEP;
          nxt_dst[cur_ff] = dst_ff[cur_ff] + `DMA_ADDR_STEP;
          nxt_last = cur_ff;
          nxt_have_last = 1'b1;
          nxt_active[cur_ff] = 1'b0;
          nxt_state = ST_IDLE;
          if (eop_pend_ff[cur_ff] || (cnt_last && !chained_ff[cur_ff])) begin
            nxt_done[cur_ff] = 1'b1;
            nxt_tc[cur_ff] = nxt_tc[cur_ff] | cnt_last;
            nxt_irq[cur_ff] = 1'b1;
            nxt_setup_ok[cur_ff] = 1'b0;
            nxt_eop_pend[cur_ff] = 1'b0;
          end else if (cnt_last) begin
            nxt_desc_need[cur_ff] = 1'b1;
          end else if (block_ff[cur_ff] && eff_en[cur_ff] && run_ok) begin
            nxt_active[cur_ff] = 1'b1;
            nxt_xsrc = src_ff[cur_ff] + `DMA_ADDR_STEP;
            nxt_xdst = dst_ff[cur_ff] + `DMA_ADDR_STEP;
            nxt_state = ST_SERVE;
          end
        end
      end
      ST_DESC: begin
        if (desc_done_i) begin
          nxt_wait[cur_ff] = 1'b1;
          nxt_desc_need[cur_ff] = 1'b0;
          nxt_state = ST_IDLE;
          if (desc_null_i) begin
            nxt_tc[cur_ff] = 1'b1;
            nxt_done[cur_ff] = 1'b1;
            nxt_irq[cur_ff] = 1'b1;
            nxt_setup_ok[cur_ff] = 1'b0;
          end else begin
            nxt_cnt[cur_ff] = desc_count_i;
            nxt_src[cur_ff] = desc_src_i;
            nxt_dst[cur_ff] = desc_dst_i;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase

    if (setup_valid_i) begin
      // Setup aborts and reloads, no done
      nxt_setup_ok[setup_chan_i]  = 1'b1;
      nxt_chained[setup_chan_i]   = setup_chained_i;
      nxt_block[setup_chan_i]     = setup_block_i;
      nxt_wait_en[setup_chan_i]   = setup_wait_en_i;
      nxt_cnt[setup_chan_i]       = setup_count_i;
      nxt_src[setup_chan_i]       = setup_src_i;
      nxt_dst[setup_chan_i]       = setup_dst_i;
      nxt_desc_need[setup_chan_i] = 1'b0;
      nxt_eop_pend[setup_chan_i]  = 1'b0;
      nxt_active[setup_chan_i]    = 1'b0;
      nxt_irq[setup_chan_i]       = 1'b0;
      if ((state_ff == ST_SERVE || state_ff == ST_DESC) && cur_ff == setup_chan_i) begin
        nxt_state = ST_IDLE;
        nxt_done[setup_chan_i] = sfr_wr_i ? nxt_done[setup_chan_i] : done_ff[setup_chan_i];
        nxt_tc[setup_chan_i]   = sfr_wr_i ? nxt_tc[setup_chan_i] : tc_ff[setup_chan_i];
      end else if (state_ff == ST_SAVE && save_ch_ff == setup_chan_i) begin
        nxt_state = ST_IDLE;
      end
    end
  end

  // ========================================================================
  // State registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;   enable_ff <= 4'h0;   tc_ff <= 4'h0;      active_ff <= 4'h0;
      done_ff <= 4'h0;       wait_ff <= 4'h0;     irq_ff <= 4'h0;     prio_ff <= 1'b0;
      throttle_ff <= 1'b0;   setup_ok_ff <= 4'h0; chained_ff <= 4'h0; block_ff <= 4'h0;
      wait_en_ff <= 4'h0;    desc_need_ff <= 4'h0; eop_pend_ff <= 4'h0;
      cnt_ff <= '0;          src_ff <= '0;        dst_ff <= '0;
      xsrc_ff <= 32'h0;      xdst_ff <= 32'h0;    cur_ff <= 2'h0;     last_ff <= 2'h3;
      save_ch_ff <= 2'h0;    have_last_ff <= 1'b0; ret_serve_ff <= 1'b0;
      flush_pend_ff <= 1'b0; flush_ch_ff <= 2'h0; widx_ff <= 3'h0;    run_cnt_ff <= 3'h0;
      ram_we_ff <= 1'b0;     ram_waddr_ff <= 5'h00; ram_wdata_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;   enable_ff <= nxt_enable;     tc_ff <= nxt_tc;
      active_ff <= nxt_active; done_ff <= nxt_done;         wait_ff <= nxt_wait;
      irq_ff <= nxt_irq;       prio_ff <= nxt_prio;         throttle_ff <= nxt_throttle;
      setup_ok_ff <= nxt_setup_ok; chained_ff <= nxt_chained; block_ff <= nxt_block;
      wait_en_ff <= nxt_wait_en; desc_need_ff <= nxt_desc_need; eop_pend_ff <= nxt_eop_pend;
      cnt_ff <= nxt_cnt;       src_ff <= nxt_src;           dst_ff <= nxt_dst;
      xsrc_ff <= nxt_xsrc;     xdst_ff <= nxt_xdst;         cur_ff <= nxt_cur;
      last_ff <= nxt_last;     save_ch_ff <= nxt_save_ch;   have_last_ff <= nxt_have_last;
      ret_serve_ff <= nxt_ret_serve; flush_pend_ff <= nxt_flush_pend;
      flush_ch_ff <= nxt_flush_ch; widx_ff <= nxt_widx;     run_cnt_ff <= nxt_run_cnt;
      ram_we_ff <= nxt_ram_we; ram_waddr_ff <= nxt_ram_waddr; ram_wdata_ff <= nxt_ram_wdata;
    end
  end

  // ========================================================================
  // State RAM and outputs
  state_ram_if ram_bus ();
  assign ram_bus.we    = ram_we_ff;
  assign ram_bus.waddr = ram_waddr_ff;
  assign ram_bus.wdata = ram_wdata_ff;
  assign ram_bus.raddr = ram_rd_addr_i;
  assign ram_rdata_o   = ram_bus.rdata;

  dma_state_ram #(.WORDS(`DMA_RAM_WORDS)) u_state_ram (
    .clock_i (clock_i),
    .ram     (ram_bus)
  );

  // Register read image, upper bits zero
  assign sfr_rdata_o = {{`DMA_RSVD_WIDTH{1'b0}}, throttle_ff, prio_ff, wait_ff, done_ff,
                        active_ff, tc_ff, enable_ff};
  assign bus_req_o   = state_ff == ST_SERVE;
  assign bus_chan_o  = cur_ff;
  assign bus_src_o   = xsrc_ff;
  assign bus_dst_o   = xdst_ff;
  assign desc_req_o  = state_ff == ST_DESC;
  assign desc_chan_o = cur_ff;
  assign interrupt_pending_set_o = irq_ff;

  // ========================================================================
  // Assertions
  logic start_serve;
  assign start_serve = state_ff == ST_IDLE && nxt_state == ST_SERVE;

  a_enable_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !sfr_wr_i |=> enable_ff == $past(enable_ff))
    else $error("enable changed without a software write");

  a_tc_after_bus: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ((tc_ff & ~$past(tc_ff)) != 4'h0 && !$past(sfr_wr_i)) |->
      $past(state_ff == ST_SERVE && bus_done_i || state_ff == ST_DESC && desc_done_i))
    else $error("terminal count set outside bus completion");

  a_setup_no_done: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (setup_valid_i && !sfr_wr_i && state_ff == ST_SERVE && cur_ff == setup_chan_i) |=>
      done_ff == $past(done_ff) && state_ff == ST_IDLE)
    else $error("aborted channel got done or kept serving");

  a_fixed_order: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (start_serve && !prio_ff) |-> (elig & ((4'h1 << grant_ch) - 4'h1)) == 4'h0)
    else $error("fixed mode skipped a higher priority channel");

  a_rotate_next: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (start_serve && prio_ff && elig[last_ff + 2'h1]) |=> cur_ff == $past(last_ff) + 2'h1)
    else $error("rotating mode did not favour next channel");

  a_irq_suspend: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (interrupt_control_register_suspend_i && ctx_switch_i && state_ff == ST_IDLE) |=> state_ff != ST_SERVE)
    else $error("channel served during context switch");

  a_throttle_gap: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (throttle_ff && state_ff == ST_IDLE && run_cnt_ff != 3'h0) |=> state_ff != ST_SERVE)
    else $error("throttle allowed back to back DMA clocks");

  a_demand_active: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_ff == ST_SERVE && bus_done_i && !block_ff[cur_ff] && !setup_valid_i) |=>
      !active_ff[$past(cur_ff)] && !bus_req_o)
    else $error("demand mode active bit outlived the request");

endmodule

// file: verification/bus_unit_model.sv
// Bus unit model: answers each held request with one done pulse.
// Assumes a request holds until the edge that samples its done pulse.
`timescale 1ns/1ns
module bus_unit_model (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic slow_i,
  input  wire logic req_i,
  output logic      done_o
);
  logic [2:0] wait_ff;
  // Count wait states, then pulse done once per request
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_ff <= 3'h0;
      done_o  <= 1'b0;
    end else begin
      done_o  <= req_i && !done_o && (wait_ff >= (slow_i ? 3'h4 : 3'h0));
      wait_ff <= (req_i && !done_o) ? wait_ff + 3'h1 : 3'h0;
    end
  end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the DMA control block.
// Assumes the design, its package and the bus unit model are compiled first.
`timescale 1ns/1ns
module testbench;
  logic        clock_i = 1'b0, resetn_i = 1'b0, sfr_wr_i = 1'b0, setup_valid_i = 1'b0;
  logic        interrupt_control_register_suspend_i = 1'b0, ctx_switch_i = 1'b0, slow_i = 1'b0, flush_i = 1'b0;
  logic        bus_req_o, bus_done_i, desc_req_o, desc_done_i, setup_chained_i = 1'b0;
  logic [1:0]  setup_chan_i = 2'h0, bus_chan_o, desc_chan_o, seen = 2'h0;
  logic [3:0]  dreq_i = 4'h0, interrupt_pending_set_o, end_of_process_inputs_n_i = 4'hf;
  logic [4:0]  ram_rd_addr_i = 5'h00;
  logic [31:0] sfr_wdata_i = '0, setup_count_i = '0, setup_src_i = '0, rnd = 32'hfe851ff0;
  logic [31:0] sfr_rdata_o, bus_src_o, bus_dst_o, ram_rdata_o, a, b;
  logic [33:0] grant_q[$];
  logic [3:0]  irq_q[$];
  int          n_errors = 0, check_count = 0;

  always #4 clock_i = ~clock_i;
  // Pseudo-random source, also feeding unused data inputs
  always @(posedge clock_i) rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};

  dma_channel_control_priority i_dma_channel_control_priority (.clock_i, .resetn_i,
    .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .setup_valid_i, .setup_chan_i,
    .setup_chained_i, .setup_block_i(1'b0), .setup_wait_en_i(rnd[0]), .setup_count_i,
    .setup_src_i, .setup_dst_i(setup_src_i + 32'h100), .interrupt_control_register_suspend_i, .ctx_switch_i,
    .flush_i, .flush_chan_i(setup_chan_i), .dreq_i, .end_of_process_inputs_n_i, .bus_req_o,
    .bus_chan_o, .bus_src_o, .bus_dst_o, .bus_done_i, .desc_req_o, .desc_chan_o,
    .desc_done_i, .desc_null_i(1'b1), .desc_count_i(rnd), .desc_src_i(rnd),
    .desc_dst_i(rnd), .interrupt_pending_set_o, .ram_rd_addr_i, .ram_rdata_o);
  bus_unit_model i_bus_unit_model (.clock_i, .resetn_i, .slow_i, .req_i(bus_req_o),
    .done_o(bus_done_i));
  bus_unit_model i_bus_unit_model_desc (.clock_i, .resetn_i, .slow_i, .req_i(desc_req_o),
    .done_o(desc_done_i));

  task automatic fail(string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic check_grant(logic [33:0] got, logic [31:0] dst);
    check_count++;
    if (grant_q.size() == 0 || grant_q.pop_front() !== got || dst !== got[31:0] + 32'h100)
      fail("grant channel or address");
  endtask
  task automatic check_ram(logic [4:0] ad, logic [31:0] exp);
    ram_rd_addr_i <= ad;
    repeat (2) @(posedge clock_i);
    check_count++;
    if (ram_rdata_o !== exp) fail("state RAM word");
  endtask
  task automatic check_irq(logic [3:0] got);
    check_count++;
    if (irq_q.size() == 0 || irq_q.pop_front() !== got) fail("interrupt pulse");
  endtask
  task automatic check_reg(logic [31:0] exp);
    @(posedge clock_i);
    #1 check_count++;
    if (sfr_rdata_o !== exp) fail("register image");
  endtask
  task automatic wr(logic [31:0] d);
    @(posedge clock_i);
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic setup(logic [1:0] ch, logic [31:0] n, logic [31:0] s);
    @(posedge clock_i);
    setup_valid_i <= 1'b1;
    setup_chan_i <= ch;
    setup_count_i <= n;
    setup_src_i <= s;
    @(posedge clock_i);
    setup_valid_i <= 1'b0;
  endtask
  task automatic drain(string name);
    int i;
    for (i = 0; i < 400 && grant_q.size() + irq_q.size() > 0; i++) @(posedge clock_i);
    if (i == 400) begin
      fail("timeout");
      wrap_up();
    end
    repeat (4) @(posedge clock_i);
    $display("test %s done", name);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare each new grant and each interrupt pulse with the oldest note
  always @(posedge clock_i) begin
    seen <= {desc_req_o, bus_req_o};
    if (bus_req_o === 1'b1 && seen[0] !== 1'b1)
      check_grant({bus_chan_o, bus_src_o}, bus_dst_o);
    if (desc_req_o === 1'b1 && seen[1] !== 1'b1)
      check_grant({desc_chan_o, 32'h0}, 32'h100);
    // Flops are unknown until the first reset edge
    if (resetn_i === 1'b1 && interrupt_pending_set_o !== 4'h0)
      check_irq(interrupt_pending_set_o);
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    check_reg(32'h0);
    wr(32'hffffffff);
    check_reg(32'h003ff0ff);
    wr(32'h0);
    check_reg(32'h0);
    $display("test register done");
    a = rnd;
    setup(2'h0, 32'h2, a);
    grant_q.push_back({2'h0, a});
    grant_q.push_back({2'h0, a + 32'h4});
    irq_q.push_back(4'h1);
    dreq_i <= 4'h1;
    wr(32'h1);
    drain("demand");
    check_reg(32'h00001011);
    dreq_i <= 4'h0;
    slow_i <= 1'b1;
    wr(32'h0);
    a = rnd;
    setup(2'h3, 32'h1, a);
    b = rnd;
    setup(2'h1, 32'h1, b);
    grant_q.push_back({2'h1, b});
    grant_q.push_back({2'h3, a});
    irq_q.push_back(4'h2);
    irq_q.push_back(4'h8);
    dreq_i <= 4'ha;
    repeat (4) @(posedge clock_i);
    wr(32'ha);
    drain("fixed");
    dreq_i <= 4'h0;
    wr(32'h00100000);
    a = rnd;
    setup(2'h0, 32'h2, a);
    b = rnd;
    setup(2'h1, 32'h2, b);
    grant_q.push_back({2'h0, a});
    grant_q.push_back({2'h1, b});
    grant_q.push_back({2'h0, a + 32'h4});
    grant_q.push_back({2'h1, b + 32'h4});
    irq_q.push_back(4'h1);
    irq_q.push_back(4'h2);
    dreq_i <= 4'h3;
    repeat (4) @(posedge clock_i);
    wr(32'h00300003);
    drain("rotating");
    check_reg(32'h00303033);
    dreq_i <= 4'h0;
    slow_i <= 1'b0;
    interrupt_control_register_suspend_i <= 1'b1;
    ctx_switch_i <= 1'b1;
    wr(32'h0);
    a = rnd;
    setup(2'h2, 32'h1, a);
    dreq_i <= 4'h4;
    wr(32'h4);
    // Any grant in this window has no note and counts as a mismatch
    repeat (20) @(posedge clock_i);
    grant_q.push_back({2'h2, a});
    irq_q.push_back(4'h4);
    ctx_switch_i <= 1'b0;
    drain("suspend");
    interrupt_control_register_suspend_i <= 1'b0;
    wr(32'h0);
    setup_chained_i <= 1'b1;
    a = rnd;
    setup(2'h1, 32'h1, a);
    setup_chained_i <= 1'b0;
    grant_q.push_back({2'h1, a});
    grant_q.push_back({2'h1, 32'h0});
    irq_q.push_back(4'h2);
    dreq_i <= 4'h2;
    wr(32'h2);
    drain("chained");
    check_reg(32'h00022022);
    wr(32'h0);
    a = rnd;
    setup(2'h0, 32'h8, a);
    end_of_process_inputs_n_i <= 4'he;
    repeat (4) @(posedge clock_i);
    end_of_process_inputs_n_i <= 4'hf;
    grant_q.push_back({2'h0, a});
    irq_q.push_back(4'h1);
    dreq_i <= 4'h1;
    wr(32'h1);
    drain("eop");
    check_reg(32'h00001001);
    dreq_i <= 4'h0;
    a = rnd;
    setup(2'h3, 32'h5, a);
    flush_i <= 1'b1;
    @(posedge clock_i);
    flush_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    check_ram(5'h18, a);
    check_ram(5'h19, a + 32'h100);
    check_ram(5'h1a, 32'h5);
    $display("test flush done");
    wrap_up();
  end
endmodule
